// ==== dac_sync_host.sv ====
// host end: bring-up sequencer driving reset, config writes and sync
`timescale 1ns/1ps
`default_nettype none
module dac_sync_host
  import dac_sync_pkg::*;
#(
  parameter int SETTLE_CYC = CLK_SETTLE_CYC
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rstn,
  // command port
  input  wire logic [3:0]         cmdAddr,
  input  wire logic [DATA_W-1:0]  cmdWdata,
  input  wire logic               cmdWr,
  input  wire logic               cmdRd,
  output logic [DATA_W-1:0]       cmdRdata,
  // sample flow permission
  output logic                    dataFlowEn,
  // link to converter
  dac_sync_if.host                link
);
  import dac_sync_pkg::*;

  typedef enum logic [6:0] {
    H_IDLE  = 7'b0000001,
    H_RST   = 7'b0000010,
    H_CLK   = 7'b0000100,
    H_PROG  = 7'b0001000,
    H_SYNC  = 7'b0010000,
    H_WAIT  = 7'b0100000,
    H_RUN   = 7'b1000000
  } host_e;

  // shadow value slots sit from HOST_CFG0 upward, one per converter shadow
  function automatic logic isCfg(input logic [3:0] a);
    return (a >= HOST_CFG0) && (a <= HOST_CFG0 + 4'(SHADOW_N - 1));
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // command registers: control, sync source and mode, shadow values
  host_e             state_q, state_d;
  logic [DATA_W-1:0] ctrl_q, ctrl_d;
  logic [DATA_W-1:0] cfg_q [SHADOW_N];
  logic [DATA_W-1:0] cfg_d [SHADOW_N];
  logic [DATA_W-1:0] devStat_q, devStat_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic              start;
  logic [4:0]        cnt_q, cnt_d;
  logic              rstLow_q, rstLow_d;
  logic              gate_q, gate_d;
  logic              sync_q, sync_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] wdata_q, wdata_d;
  logic              wr_q, wr_d;
  logic              rd_q, rd_d;
  logic              rdPend_q, rdPend_d;
  logic              flow_q, flow_d;

  // start bit is a pulse; bits 2:1 source, bits 4:3 clock mode
  assign start = cmdWr && (cmdAddr == HOST_CTRL) && cmdWdata[HCTRL_START_BIT];

  always_comb begin
    ctrl_d  = ctrl_q;
    rdata_d = 8'h00;
    for (int i = 0; i < SHADOW_N; i++) begin
      cfg_d[i] = cfg_q[i];
    end
    if (cmdWr && cmdAddr == HOST_CTRL) begin
      ctrl_d = {cmdWdata[7:1], 1'b0};
    end else if (cmdWr && isCfg(cmdAddr)) begin
      cfg_d[3'(cmdAddr - HOST_CFG0)] = cmdWdata;
    end
    if (cmdRd) begin
      if (cmdAddr == HOST_CTRL) begin
        rdata_d = ctrl_q;
      end else if (cmdAddr == HOST_STATUS) begin
        rdata_d = {devStat_q[3:0], flow_q, 1'b0, ctrl_q[2:1] == SRC_SOFT, state_q == H_IDLE};
      end else if (isCfg(cmdAddr)) begin
        rdata_d = cfg_q[3'(cmdAddr - HOST_CFG0)];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // bring-up sequence: reset, clock settle, program, sync, data
  always_comb begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    rstLow_d  = 1'b1;
    gate_d    = gate_q;
    sync_d    = 1'b0;
    addr_d    = addr_q;
    wdata_d   = wdata_q;
    wr_d      = 1'b0;
    rd_d      = 1'b0;
    rdPend_d  = rd_q;
    flow_d    = flow_q;
    devStat_d = rdPend_q ? link.cfgRdata : devStat_q;
    unique case (state_q)
      H_IDLE: begin
        cnt_d = 5'h0;
        if (start) begin
          state_d  = H_RST;
          rstLow_d = 1'b0;
          gate_d   = 1'b0;
          flow_d   = 1'b0;
        end
      end
      H_RST: begin
        rstLow_d = 1'b0;
        cnt_d    = cnt_q + 5'h1;
        if (cnt_q == 5'(RESET_LOW_CYC + SYNC_PIN_CYC)) begin
          state_d  = H_CLK;
          rstLow_d = 1'b1;
          cnt_d    = 5'h0;
        end
      end
      H_CLK: begin
        cnt_d = cnt_q + 5'h1;
        if (cnt_q == 5'(SETTLE_CYC - 1)) begin
          state_d = H_PROG;
          cnt_d   = 5'h0;
        end
      end
      H_PROG: begin
        wr_d  = 1'b1;
        cnt_d = cnt_q + 5'h1;
        if (cnt_q == 5'h0) begin
          addr_d  = SYNC_SEL_A;
          wdata_d = {6'h00, ctrl_q[2:1]};
        end else if (cnt_q == 5'h1) begin
          addr_d  = SYNC_SEL_B;
          wdata_d = {6'h00, ctrl_q[4:3]};
        end else begin
          addr_d  = SHADOW_FIRST + 5'(cnt_q - 5'h2);
          wdata_d = cfg_q[3'(cnt_q - 5'h2)];
        end
        if (cnt_q == 5'(PROG_N - 1)) begin
          state_d = H_SYNC;
          cnt_d   = 5'h0;
        end
      end
      H_SYNC: begin
        cnt_d = cnt_q + 5'h1;
        // gate or pin source: one shared pin drive reaches every converter in the same edge; soft source writes SYNC_CTRL once
        if (ctrl_q[2:1] == SRC_GATE) begin
          gate_d = 1'b1;
        end else if (ctrl_q[2:1] == SRC_PIN) begin
          sync_d = 1'b1;
        end else if (cnt_q == 5'h0) begin
          wr_d    = 1'b1;
          addr_d  = SYNC_CTRL;
          wdata_d = 8'h01;
        end
        if (cnt_q == 5'(SYNC_PIN_CYC - 1)) begin
          state_d = H_WAIT;
          cnt_d   = 5'h0;
        end
      end
      H_WAIT: begin
        cnt_d = cnt_q + 5'h1;
        if (cnt_q == 5'(SYNC_WAIT_CYC - 1)) begin
          state_d = H_RUN;
          rd_d    = 1'b1;
          addr_d  = DEV_STATUS;
          flow_d  = 1'b1;
        end
      end
      H_RUN: begin
        if (start) begin
          state_d  = H_RST;
          rstLow_d = 1'b0;
          cnt_d    = 5'h0;
          gate_d   = 1'b0;
          flow_d   = 1'b0;
        end
      end
      default: state_d = H_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q   <= H_IDLE;
      ctrl_q    <= 8'h00;
      devStat_q <= 8'h00;
      rdata_q   <= 8'h00;
      cnt_q     <= 5'h0;
      rstLow_q  <= 1'b1;
      gate_q    <= 1'b0;
      sync_q    <= 1'b0;
      addr_q    <= 5'h00;
      wdata_q   <= 8'h00;
      wr_q      <= 1'b0;
      rd_q      <= 1'b0;
      rdPend_q  <= 1'b0;
      flow_q    <= 1'b0;
      for (int i = 0; i < SHADOW_N; i++) begin
        cfg_q[i] <= 8'h00;
      end
    end else begin
      state_q   <= state_d;
      ctrl_q    <= ctrl_d;
      devStat_q <= devStat_d;
      rdata_q   <= rdata_d;
      cnt_q     <= cnt_d;
      rstLow_q  <= rstLow_d;
      gate_q    <= gate_d;
      sync_q    <= sync_d;
      addr_q    <= addr_d;
      wdata_q   <= wdata_d;
      wr_q      <= wr_d;
      rd_q      <= rd_d;
      rdPend_q  <= rdPend_d;
      flow_q    <= flow_d;
      for (int i = 0; i < SHADOW_N; i++) begin
        cfg_q[i] <= cfg_d[i];
      end
    end
  end

  assign cmdRdata            = rdata_q;
  assign dataFlowEn          = flow_q;
  assign link.deviceResetLow = rstLow_q;
  assign link.transmitGatePin = gate_q;
  assign link.syncPin        = sync_q;
  assign link.cfgAddr        = addr_q;
  assign link.cfgWdata       = wdata_q;
  assign link.cfgWr          = wr_q;
  assign link.cfgRd          = rd_q;
endmodule
`default_nettype wire

// ==== dac_sync_pkg.sv ====
// shared constants for the converter start-up and sync link
package dac_sync_pkg;
  // clock and timing
  localparam int CLK_PERIOD_NS   = 25;
  localparam int RESET_LOW_NS    = 25;
  localparam int RESET_LOW_CYC   = (RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLK_SETTLE_CYC  = 16;
  localparam int SYNC_PIN_CYC    = 2;
  localparam int SYNC_LAT_CYC    = 4;
  localparam int SYNC_WAIT_CYC   = 12;
  // link widths
  localparam int ADDR_W          = 5;
  localparam int DATA_W          = 8;
  localparam int SHADOW_N        = 8;
  // device register map
  localparam logic [4:0] DEV_STATUS   = 5'h00;
  localparam logic [4:0] SYNC_CTRL    = 5'h05;
  localparam logic [4:0] SHADOW_FIRST = 5'h06;
  localparam logic [4:0] SHADOW_LAST  = 5'h0D;
  localparam logic [4:0] SYNC_SEL_A   = 5'h16;
  localparam logic [4:0] SYNC_SEL_B   = 5'h17;
  // field positions and reset values
  localparam int SOFT_SYNC_BIT        = 0;
  localparam int STAT_SEEN_BIT        = 0;
  localparam int STAT_EXACT_BIT       = 1;
  localparam logic [7:0] SEL_A_RST    = 8'h00;
  localparam logic [7:0] SEL_B_RST    = 8'h15;
  localparam logic [7:0] SHADOW_RST   = 8'h00;
  // sync sources and clock modes
  localparam logic [1:0] SRC_GATE     = 2'h0;
  localparam logic [1:0] SRC_PIN      = 2'h1;
  localparam logic [1:0] SRC_SOFT     = 2'h2;
  localparam logic [1:0] MODE_EXT     = 2'h0;
  localparam logic [1:0] MODE_DUAL    = 2'h1;
  localparam logic [1:0] MODE_DSYNC   = 2'h2;
  // host register map
  localparam logic [3:0] HOST_CTRL    = 4'h0;
  localparam logic [3:0] HOST_STATUS  = 4'h1;
  localparam logic [3:0] HOST_CFG0    = 4'h2;
  localparam int HCTRL_START_BIT      = 0;
  localparam int PROG_N               = SHADOW_N + 2;
endpackage

// ==== dac_sync_if.sv ====
// pins between the host controller and the converter control logic
`timescale 1ns/1ps
`default_nettype none
interface dac_sync_if;
  import dac_sync_pkg::*;
  logic              deviceResetLow;  // active-low device reset
  logic              transmitGatePin; // transmit gate, sync source
  logic              syncPin;         // dedicated sync input
  logic [ADDR_W-1:0] cfgAddr;
  logic [DATA_W-1:0] cfgWdata;
  logic              cfgWr;
  logic              cfgRd;
  logic [DATA_W-1:0] cfgRdata;        // valid the cycle after cfgRd
  modport device (input deviceResetLow, transmitGatePin, syncPin, cfgAddr, cfgWdata,
                  cfgWr, cfgRd, output cfgRdata);
  modport host (output deviceResetLow, transmitGatePin, syncPin, cfgAddr, cfgWdata,
                cfgWr, cfgRd, input cfgRdata);
endinterface
`default_nettype wire

// ==== dac_sync_device.sv ====
// converter end: pin capture, config registers, shadow transfer on sync
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - host holds reset low at least 25 ns
// - host order: reset, clock, program, sync, data
// - sync from gate pin, sync pin or software
// - shadowed registers go active only on sync
// - host syncs all converters at once
// - multi-converter sync uses a pin, not software
// - external and dual modes align within one cycle
// - dual synchronous mode has constant latency
module dac_sync_device
  import dac_sync_pkg::*;
#(
  parameter int SYNC_LAT = SYNC_LAT_CYC
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rstn,
  // link to host
  dac_sync_if.device                      link,
  // active configuration and sync status
  output logic [SHADOW_N*DATA_W-1:0]      activeCfg,
  output logic                            syncEvent,
  output logic                            exactAlign
);
  import dac_sync_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b001,
    S_ALIGN = 3'b010,
    S_LAT   = 3'b100
  } xfer_e;

  function automatic logic isShadow(input logic [ADDR_W-1:0] a);
    return (a >= SHADOW_FIRST) && (a <= SHADOW_LAST);
  endfunction

  function automatic logic [2:0] shadowIdx(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] d;
    d = a - SHADOW_FIRST;
    return d[2:0];
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // pin capture: two flops, then edge detection on the second stage
  logic [2:0] pinMeta_q, pinMeta_d;
  logic [2:0] pinSync_q, pinSync_d;
  logic [2:0] pinPrev_q, pinPrev_d;
  logic       devReset;
  logic       gateRise;
  logic       syncRise;

  always_comb begin
    pinMeta_d = {link.deviceResetLow, link.transmitGatePin, link.syncPin};
    pinSync_d = pinMeta_q;
    pinPrev_d = pinSync_q;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pinMeta_q <= 3'h4; // idle levels: pin reset high, gate and sync low
      pinSync_q <= 3'h4;
      pinPrev_q <= 3'h4;
    end else begin
      pinMeta_q <= pinMeta_d;
      pinSync_q <= pinSync_d;
      pinPrev_q <= pinPrev_d;
    end
  end

  // pin reset takes effect on its synchronised level; width is host's job
  assign devReset = !pinSync_q[2];
  assign gateRise = pinSync_q[1] && !pinPrev_q[1];
  assign syncRise = pinSync_q[0] && !pinPrev_q[0];

  //////////////////////////////////////////////////////////////////////////
  // configuration registers written over the link
  logic [DATA_W-1:0] selA_q, selA_d;
  logic [DATA_W-1:0] selB_q, selB_d;
  logic              softSync_q, softSync_d;
  logic [DATA_W-1:0] shadow_q [SHADOW_N];
  logic [DATA_W-1:0] shadow_d [SHADOW_N];
  logic              seen_q, seen_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic              doXfer;
  logic [1:0]        clkMode;

  assign clkMode = selB_q[1:0];

  always_comb begin
    selA_d     = selA_q;
    selB_d     = selB_q;
    softSync_d = 1'b0; // software sync bit clears itself
    seen_d     = seen_q || doXfer;
    rdata_d    = 8'h00;
    for (int i = 0; i < SHADOW_N; i++) begin
      shadow_d[i] = shadow_q[i];
    end
    if (link.cfgWr) begin
      unique case (1'b1)
        link.cfgAddr == SYNC_SEL_A: selA_d = link.cfgWdata;
        link.cfgAddr == SYNC_SEL_B: selB_d = link.cfgWdata;
        link.cfgAddr == SYNC_CTRL:  softSync_d = link.cfgWdata[SOFT_SYNC_BIT];
        isShadow(link.cfgAddr):     shadow_d[shadowIdx(link.cfgAddr)] = link.cfgWdata;
        default: ;
      endcase
    end
    if (link.cfgRd) begin
      if (link.cfgAddr == DEV_STATUS) begin
        rdata_d[STAT_SEEN_BIT]  = seen_q;
        rdata_d[STAT_EXACT_BIT] = (clkMode == MODE_DSYNC);
        rdata_d[3:2]            = clkMode;
      end else if (link.cfgAddr == SYNC_SEL_A) begin
        rdata_d = selA_q;
      end else if (link.cfgAddr == SYNC_SEL_B) begin
        rdata_d = selB_q;
      end else if (isShadow(link.cfgAddr)) begin
        rdata_d = shadow_q[shadowIdx(link.cfgAddr)];
      end
    end
    if (devReset) begin
      selA_d     = SEL_A_RST;
      selB_d     = SEL_B_RST;
      softSync_d = 1'b0;
      seen_d     = 1'b0;
      for (int i = 0; i < SHADOW_N; i++) begin
        shadow_d[i] = SHADOW_RST;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      selA_q     <= SEL_A_RST;
      selB_q     <= SEL_B_RST;
      softSync_q <= 1'b0;
      seen_q     <= 1'b0;
      rdata_q    <= 8'h00;
      for (int i = 0; i < SHADOW_N; i++) begin
        shadow_q[i] <= SHADOW_RST;
      end
    end else begin
      selA_q     <= selA_d;
      selB_q     <= selB_d;
      softSync_q <= softSync_d;
      seen_q     <= seen_d;
      rdata_q    <= rdata_d;
      for (int i = 0; i < SHADOW_N; i++) begin
        shadow_q[i] <= shadow_d[i];
      end
    end
  end

  assign link.cfgRdata = rdata_q;

  //////////////////////////////////////////////////////////////////////////
  // sync source select and transfer timing
  xfer_e             state_q, state_d;
  logic [3:0]        latCnt_q, latCnt_d;
  logic              phase_q, phase_d;
  logic              rawEvt;
  logic [SHADOW_N*DATA_W-1:0] active_q, active_d;
  logic              syncEvent_q, syncEvent_d;
  logic              exact_q, exact_d;

  // one selected source; an unused code never syncs
  always_comb begin
    unique case (selA_q[1:0])
      SRC_GATE: rawEvt = gateRise;
      SRC_PIN:  rawEvt = syncRise;
      SRC_SOFT: rawEvt = softSync_q;
      default:  rawEvt = 1'b0;
    endcase
  end

  // free-running fifo read phase; non-synchronous modes wait for it
  always_comb begin
    state_d     = state_q;
    latCnt_d    = latCnt_q;
    phase_d     = !phase_q;
    active_d    = active_q;
    syncEvent_d = 1'b0;
    doXfer      = 1'b0;
    exact_d     = (clkMode == MODE_DSYNC);
    unique case (state_q)
      S_IDLE: begin
        latCnt_d = 4'h0;
        // one event per transfer; further events while busy are dropped
        if (rawEvt) begin
          if (clkMode == MODE_DSYNC) begin
            state_d = S_LAT;
          end else begin
            state_d = S_ALIGN;
          end
        end
      end
      S_ALIGN: begin
        if (phase_q) begin
          state_d = S_LAT;
        end
      end
      S_LAT: begin
        latCnt_d = latCnt_q + 4'h1;
        if (latCnt_q == 4'(SYNC_LAT - 1)) begin
          state_d     = S_IDLE;
          doXfer      = 1'b1;
          syncEvent_d = 1'b1;
          for (int i = 0; i < SHADOW_N; i++) begin
            active_d[i*DATA_W +: DATA_W] = shadow_q[i];
          end
        end
      end
      default: state_d = S_IDLE;
    endcase
    if (devReset) begin
      state_d     = S_IDLE;
      latCnt_d    = 4'h0;
      syncEvent_d = 1'b0;
      doXfer      = 1'b0;
      active_d    = '0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q     <= S_IDLE;
      latCnt_q    <= 4'h0;
      phase_q     <= 1'b0;
      active_q    <= '0;
      syncEvent_q <= 1'b0;
      exact_q     <= 1'b0;
    end else begin
      state_q     <= state_d;
      latCnt_q    <= latCnt_d;
      phase_q     <= phase_d;
      active_q    <= active_d;
      syncEvent_q <= syncEvent_d;
      exact_q     <= exact_d;
    end
  end

  assign activeCfg  = active_q;
  assign syncEvent  = syncEvent_q;
  assign exactAlign = exact_q;
endmodule
`default_nettype wire

// ==== dac_sync_properties.sv ====
// concurrent checks on the link between the host sequencer and the converter
`timescale 1ns/1ps
`default_nettype none
module dac_sync_properties (
  // clock and reset
  input wire logic                        clk,
  input wire logic                        rstn,
  // link pins driven by the host
  input wire logic                        deviceResetLow,
  input wire logic                        transmitGatePin,
  input wire logic                        syncPin,
  input wire logic [dac_sync_pkg::ADDR_W-1:0] cfgAddr,
  input wire logic [dac_sync_pkg::DATA_W-1:0] cfgWdata,
  input wire logic                        cfgWr,
  input wire logic                        cfgRd,
  // link pin driven by the converter
  input wire logic [dac_sync_pkg::DATA_W-1:0] cfgRdata
);
  import dac_sync_pkg::*;
  logic [3:0] wrCnt_q;
  logic [3:0] wrCnt_d;
  logic [1:0] mode_q;
  logic [1:0] mode_d;

  ////////////////////////////////////////////////////////////////////////////////
  // count config writes since the last pin reset and track the chosen clock mode
  always_comb begin
    wrCnt_d = wrCnt_q;
    mode_d  = mode_q;
    if (!deviceResetLow) begin
      wrCnt_d = 4'h0;
      mode_d  = SEL_B_RST[1:0];
    end else if (cfgWr) begin
      wrCnt_d = (wrCnt_q == 4'hF) ? wrCnt_q : wrCnt_q + 4'h1;
      if (cfgAddr == SYNC_SEL_B) mode_d = cfgWdata[1:0];
    end
  end

  // register the helper state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrCnt_q <= 4'h0;
      mode_q  <= SEL_B_RST[1:0];
    end else begin
      wrCnt_q <= wrCnt_d;
      mode_q  <= mode_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence sResetPulse;
    !deviceResetLow [*4];
  endsequence

  sequence sPinPulse;
    syncPin [*2] ##1 !syncPin;
  endsequence

  AST_RESET_WIDTH: assert property ($fell(deviceResetLow) |-> sResetPulse)
    else $error("device reset pulse too short");
  AST_QUIET_IN_RESET: assert property (!deviceResetLow |-> !cfgWr && !cfgRd && !syncPin
    && !transmitGatePin)
    else $error("link activity during device reset");
  AST_CLOCK_SETTLE: assert property ($rose(deviceResetLow) |-> !cfgWr [*2])
    else $error("config write before clock settle");
  AST_SYNC_AFTER_PROG: assert property (($rose(syncPin) || $rose(transmitGatePin))
    |-> wrCnt_q == 4'(PROG_N))
    else $error("sync edge before all registers programmed");
  AST_PIN_PULSE: assert property ($rose(syncPin) |-> sPinPulse)
    else $error("sync pin pulse not two cycles");
  AST_SOFT_BIT: assert property (cfgWr && cfgAddr == SYNC_CTRL |-> cfgWdata[SOFT_SYNC_BIT])
    else $error("sync control write without soft sync bit");
  AST_ONE_STROBE: assert property (!(cfgWr && cfgRd))
    else $error("read and write strobes together");
  AST_RDATA_IDLE: assert property (!$past(cfgRd) |-> cfgRdata == 8'h00)
    else $error("read data outside its cycle");
  AST_STATUS_SEEN: assert property (cfgRd && cfgAddr == DEV_STATUS
    |=> cfgRdata[STAT_SEEN_BIT])
    else $error("status read without sync seen");
  AST_STATUS_MODE: assert property (cfgRd && cfgAddr == DEV_STATUS |=> cfgRdata[3:2] == mode_q
    && cfgRdata[STAT_EXACT_BIT] == (mode_q == MODE_DSYNC))
    else $error("status clock mode or exact flag wrong");
endmodule
`default_nettype wire

// ==== tb_dac_startup_sync_control.sv ====
// self-checking bench: host sequencer and converter joined, driven through the command port
`timescale 1ns/1ps
`default_nettype none
module tb_dac_startup_sync_control;
  import dac_sync_pkg::*;
  localparam int LAT   = 4;
  localparam int LIMIT = 5000;
  logic        clk, rstn, cmdWr, cmdRd, dataFlowEn, syncEvent, exactAlign;
  logic [3:0]  cmdAddr;
  logic [7:0]  cmdWdata, cmdRdata;
  logic [63:0] activeCfg;
  int          errTotal, nTests, cycles;

  ////////////////////////////////////////////////////////////////////////////////
  // both ends joined by the link, checker beside it
  dac_sync_if link ();
  dac_sync_host #(.SETTLE_CYC(2)) u_dac_sync_host (.clk(clk), .rstn(rstn), .cmdAddr(cmdAddr),
    .cmdWdata(cmdWdata), .cmdWr(cmdWr), .cmdRd(cmdRd), .cmdRdata(cmdRdata),
    .dataFlowEn(dataFlowEn), .link(link.host));
  dac_sync_device #(.SYNC_LAT(LAT)) u_dac_sync_device (.clk(clk), .rstn(rstn),
    .link(link.device), .activeCfg(activeCfg), .syncEvent(syncEvent), .exactAlign(exactAlign));
  dac_sync_properties u_dac_sync_properties (.clk(clk), .rstn(rstn),
    .deviceResetLow(link.deviceResetLow), .transmitGatePin(link.transmitGatePin),
    .syncPin(link.syncPin), .cfgAddr(link.cfgAddr), .cfgWdata(link.cfgWdata),
    .cfgWr(link.cfgWr), .cfgRd(link.cfgRd), .cfgRdata(link.cfgRdata));

  // clock and hang guard
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errTotal++;
      stopTest();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // compare and bus tasks
  task automatic chkCfg(input string what, input logic [63:0] e, input logic [63:0] g);
    nTests++;
    if (g !== e) begin
      errTotal++;
      $display("mismatch %s expected %0h seen %0h", what, e, g);
    end
  endtask
  task automatic chkByte(input string what, input logic [7:0] e, input logic [7:0] g);
    chkCfg(what, {56'h0, e}, {56'h0, g});
  endtask
  task automatic chkBit(input string what, input logic e, input logic g);
    chkCfg(what, {63'h0, e}, {63'h0, g});
  endtask
  task automatic chkLat(input string what, input int lo, input int hi, input int got);
    nTests++;
    if (got < lo || got > hi) begin
      errTotal++;
      $display("mismatch %s expected %0d seen %0d", what, lo, got);
    end
  endtask
  task automatic cmdWrite(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    cmdAddr  <= a;
    cmdWdata <= d;
    cmdWr    <= 1'h1;
    @(posedge clk);
    cmdWr    <= 1'h0;
  endtask
  task automatic cmdRead(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    cmdAddr <= a;
    cmdRd   <= 1'h1;
    @(posedge clk);
    cmdRd   <= 1'h0;
    @(negedge clk);
    d = cmdRdata;
  endtask
  task automatic doReset();
    rstn <= 1'h0;
    repeat (4) @(posedge clk);
    rstn <= 1'h1;
  endtask
  task automatic stopTest();
    $display("comparisons %0d mismatches %0d", nTests, errTotal);
    if (errTotal == 0 && nTests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic testRegs();
    logic [7:0] rd;
    chkCfg("active at reset", 64'h0, activeCfg);
    chkBit("flow at reset", 1'h0, dataFlowEn);
    chkBit("exact at reset", 1'h0, exactAlign);
    cmdWrite(HOST_CFG0, 8'hA5);
    cmdRead(HOST_CFG0, rd);
    chkByte("shadow value readback", 8'hA5, rd);
    cmdRead(HOST_STATUS, rd);
    chkBit("host idle", 1'h1, rd[0]);
    cmdWrite(4'hF, 8'h3C);
    cmdRead(4'hF, rd);
    chkByte("unmapped read", 8'h00, rd);
    cmdRead(HOST_CFG0 + 4'h5, rd);
    chkByte("unmapped write ignored", 8'h00, rd);
    chkBit("no pin reset before start", 1'h1, link.deviceResetLow);
    $display("test registers done");
  endtask

  task automatic testBringup(input logic [1:0] src, input logic [1:0] mode, input logic [7:0] base);
    logic [63:0] expCfg;
    logic [63:0] prevCfg;
    logic [7:0]  rd;
    logic        pinNow;
    logic        flowEarly;
    int          n;
    int          lat;
    for (int i = 0; i < SHADOW_N; i++) begin
      expCfg[8*i +: 8] = base + 8'(i);
      cmdWrite(HOST_CFG0 + 4'(i), base + 8'(i));
    end
    cmdWrite(HOST_CTRL, {3'h0, mode, src, 1'h1});
    lat = -1;
    prevCfg = activeCfg;
    flowEarly = 1'h0;
    for (n = 0; n < 400 && syncEvent !== 1'h1; n++) begin
      prevCfg = activeCfg;
      flowEarly = dataFlowEn;
      @(negedge clk);
      pinNow = (src == SRC_GATE) ? link.transmitGatePin : link.syncPin;
      if (lat >= 0) lat++;
      else if (pinNow === 1'h1) lat = 0;
    end
    chkBit("sync pulse seen", 1'h1, syncEvent);
    chkCfg("held before sync", 64'h0, prevCfg);
    chkCfg("active after sync", expCfg, activeCfg);
    chkBit("flow held before sync", 1'h0, flowEarly);
    chkBit("exact alignment", mode == MODE_DSYNC, exactAlign);
    if (src != SRC_SOFT && mode == MODE_DSYNC) chkLat("sync latency", 3 + LAT, 3 + LAT, lat);
    if (src != SRC_SOFT && mode != MODE_DSYNC) chkLat("sync latency", 4 + LAT, 5 + LAT, lat);
    @(negedge clk);
    chkBit("single sync pulse", 1'h0, syncEvent);
    for (n = 0; n < 40 && dataFlowEn !== 1'h1; n++) @(negedge clk);
    chkBit("data flow enabled", 1'h1, dataFlowEn);
    repeat (4) @(negedge clk);
    cmdRead(HOST_STATUS, rd);
    chkByte("host status", {mode, mode == MODE_DSYNC, 3'h6, src == SRC_SOFT, 1'h0}, rd & 8'hFA);
    $display("test bringup source %0d mode %0d done", src, mode);
  endtask

  task automatic testMidReset();
    cmdWrite(HOST_CTRL, {3'h0, MODE_DSYNC, SRC_PIN, 1'h1});
    repeat (8) @(posedge clk);
    doReset();
    @(negedge clk);
    chkCfg("active after reset", 64'h0, activeCfg);
    chkBit("flow after reset", 1'h0, dataFlowEn);
    chkBit("pin reset released", 1'h1, link.deviceResetLow);
    $display("test mid reset done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rstn     = 1'h0;
    cmdWr    = 1'h0;
    cmdRd    = 1'h0;
    cmdAddr  = 4'h0;
    cmdWdata = 8'h00;
    cycles   = 0;
    errTotal = 0;
    nTests   = 0;
    doReset();
    testRegs();
    testBringup(SRC_PIN, MODE_DSYNC, 8'h10);
    testBringup(SRC_PIN, MODE_EXT, 8'h20);
    testBringup(SRC_PIN, MODE_DUAL, 8'h30);
    testMidReset();
    testBringup(SRC_GATE, MODE_DSYNC, 8'h40);
    testBringup(SRC_SOFT, MODE_DUAL, 8'h50);
    stopTest();
  end
endmodule
`default_nettype wire
